// file: logic/t1_payload_error_inserter.sv
// Function
// - corrupt payload only, T1 mode only
// - whole frame or selected channels only
// - invert Nth bit of each count
// - framing bits not counted nor inverted
// - new rate applied at frame boundary
// - code c gives one in 2^(c+3)
// - rate code zero inserts nothing
// - constant bit: insert forever, ignore count
// - counted mode stops after loaded count
// - load rising edge loads count next cycle
// - load bit edge-sensitive, holding no reload
// - ten-bit count across two registers
// - remaining count readable, split two registers
`timescale 1ns/1ps
module t1_payload_error_inserter (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // host register port
    input wire err_ins_pkg::host_req_t host_req,
    output logic [7:0] host_rdata,
    // line mode and channel scope
    input wire logic t1_mode,
    input wire logic chan_only,
    // transmit bit stream
    input wire err_ins_pkg::tx_bit_t tx_in,
    output logic tx_out_valid,
    output logic tx_out_data,
    output logic tx_out_framing,
    output logic tx_out_frame_start,
    output logic error_inserted
);
    import err_ins_pkg::*;

    logic [7:0] control_q;
    logic [7:0] count_low_q;
    logic [1:0] count_high_q;
    logic [9:0] left_q;
    logic load_prev_q;
    logic load_pending_q;
    logic [3:0] active_rate_q;
    logic [BIT_COUNT_W-1:0] bit_cnt_q;
    logic [7:0] rdata_d;
    logic [BIT_COUNT_W-1:0] limit;
    logic eligible;
    logic armed;
    logic hit;
    ins_mode_t mode;

    // host writes; bits 5 and 6 are kept as written, host owes zeros there
    // reset clears registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            control_q <= CONTROL_RESET;
            count_low_q <= 8'h00;
            count_high_q <= 2'h0;
        end else if (host_req.wr) begin
            case (host_req.addr)
                ERROR_RATE_CONTROL_ADDR: control_q <= host_req.wdata;
                ERROR_COUNT_LOW_ADDR: count_low_q <= host_req.wdata;
                ERROR_COUNT_HIGH_ADDR: count_high_q <= host_req.wdata[1:0];
                default: ;
            endcase
        end
    end

    // load bit edge detect; transfer happens on the cycle after the edge
    // edge loads next cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            load_prev_q <= 1'b0;
            load_pending_q <= 1'b0;
        end else begin
            load_prev_q <= control_q[LOAD_BIT];
            load_pending_q <= control_q[LOAD_BIT] & ~load_prev_q;
        end
    end

    // rate latched at frame start only so a frame never changes rate midway
    // rate at boundary
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            active_rate_q <= 4'h0;
        end else if (tx_in.valid && tx_in.frame_start) begin
            active_rate_q <= control_q[RATE_CODE_LSB +: 4];
        end
    end

    // mode decode
    // zero rate means off
    always_comb begin
        if (active_rate_q == 4'h0 || !t1_mode) begin
            mode = MODE_OFF;
        end else if (control_q[CONSTANT_BIT]) begin
            mode = MODE_CONSTANT;
        end else begin
            mode = MODE_COUNTED;
        end
    end

    assign limit = BIT_COUNT_W'((1 << (32'(active_rate_q) + RATE_SHIFT)) - 1);
    assign eligible = tx_in.valid && t1_mode && !tx_in.framing
        && (!chan_only || tx_in.chan_sel);
    assign armed = (mode == MODE_CONSTANT) || (mode == MODE_COUNTED && left_q != 10'h000);
    assign hit = eligible && armed && (bit_cnt_q == limit);

    // payload bit counter; it is held at zero while no insertion is armed
    // framing does not advance
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt_q <= '0;
        end else if (!armed) begin
            bit_cnt_q <= '0;
        end else if (eligible) begin
            bit_cnt_q <= (bit_cnt_q >= limit) ? '0 : bit_cnt_q + 1'b1;
        end
    end

    // remaining count: load wins over a decrement in the same cycle
    // decrement per error
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            left_q <= COUNT_RESET;
        end else if (load_pending_q) begin
            left_q <= {count_high_q, count_low_q};
        end else if (hit && mode == MODE_COUNTED) begin
            left_q <= left_q - 10'h001;
        end
    end

    // output stream, one cycle of latency
    // invert only the hit bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_out_valid <= 1'b0;
            tx_out_data <= 1'b0;
            tx_out_framing <= 1'b0;
            tx_out_frame_start <= 1'b0;
            error_inserted <= 1'b0;
        end else begin
            tx_out_valid <= tx_in.valid;
            tx_out_data <= tx_in.data ^ hit;
            tx_out_framing <= tx_in.framing;
            tx_out_frame_start <= tx_in.frame_start;
            error_inserted <= hit;
        end
    end

    // read mux
    // remaining count readable
    always_comb begin
        case (host_req.addr)
            ERROR_RATE_CONTROL_ADDR: rdata_d = control_q;
            ERROR_COUNT_LOW_ADDR: rdata_d = count_low_q;
            ERROR_COUNT_HIGH_ADDR: rdata_d = {6'h00, count_high_q};
            ERRORS_LEFT_LOW_ADDR: rdata_d = left_q[7:0];
            ERRORS_LEFT_HIGH_ADDR: rdata_d = {6'h00, left_q[9:8]};
            default: rdata_d = 8'h00;
        endcase
    end

    // registered read data, valid the cycle after rd
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            host_rdata <= 8'h00;
        end else if (host_req.rd) begin
            host_rdata <= rdata_d;
        end
    end

    // assertions
    // framing never inverted
    chk_framing_untouched: assert property (@(posedge clk) disable iff (sys_rst)
        (tx_in.valid && tx_in.framing) |=> (tx_out_data == $past(tx_in.data)))
        else $error("framing bit altered");
    chk_non_t1_clean: assert property (@(posedge clk) disable iff (sys_rst)
        !t1_mode |=> !error_inserted)
        else $error("error outside T1 mode");
    chk_zero_rate: assert property (@(posedge clk) disable iff (sys_rst)
        (active_rate_q == 4'h0) |=> !error_inserted)
        else $error("error with zero rate");
    // load two cycles after control edge
    chk_load_timing: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(control_q[LOAD_BIT]) |=> ##1 (left_q == $past({count_high_q, count_low_q})))
        else $error("count not loaded");
    chk_decrement: assert property (@(posedge clk) disable iff (sys_rst)
        (hit && mode == MODE_COUNTED && !load_pending_q) |=> (left_q == $past(left_q) - 10'h001))
        else $error("remaining not decremented");
    // no insert when count is zero in counted mode
    chk_count_stop: assert property (@(posedge clk) disable iff (sys_rst)
        (mode == MODE_COUNTED && left_q == 10'h000) |=> !error_inserted)
        else $error("insert after count exhausted");
    chk_chan_scope: assert property (@(posedge clk) disable iff (sys_rst)
        (chan_only && !tx_in.chan_sel) |=> !error_inserted)
        else $error("unselected channel corrupted");
    chk_rate_stable: assert property (@(posedge clk) disable iff (sys_rst)
        !(tx_in.valid && tx_in.frame_start) |=> $stable(active_rate_q))
        else $error("rate changed mid-frame");
    // held load bit gives no reload
    chk_no_reload: assert property (@(posedge clk) disable iff (sys_rst)
        (load_prev_q && control_q[LOAD_BIT]) |=> !load_pending_q)
        else $error("reload without edge");

    // stream pass-through, counter and readback checks
    // valid forwarded one cycle later
    chk_valid_follow: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> (tx_out_valid == $past(tx_in.valid)))
        else $error("valid not forwarded");
    chk_framing_follow: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> (tx_out_framing == $past(tx_in.framing)))
        else $error("framing mark not forwarded");
    chk_start_follow: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> (tx_out_frame_start == $past(tx_in.frame_start)))
        else $error("frame start not forwarded");
    // data changes only with an inserted error
    chk_data_xor: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> (tx_out_data == ($past(tx_in.data) ^ error_inserted)))
        else $error("data altered without error flag");
    // empty slots never carry an error
    chk_invalid_clean: assert property (@(posedge clk) disable iff (sys_rst)
        !tx_in.valid |=> !error_inserted)
        else $error("error on empty slot");
    chk_t1_off_mode: assert property (@(posedge clk) disable iff (sys_rst)
        !t1_mode |-> (mode == MODE_OFF))
        else $error("insertion armed outside T1");
    chk_framing_no_hit: assert property (@(posedge clk) disable iff (sys_rst)
        (tx_in.valid && tx_in.framing) |=> !error_inserted)
        else $error("error flagged on framing bit");
    chk_count_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (armed && !eligible) |=> $stable(bit_cnt_q))
        else $error("counter moved on ineligible bit");
    // counter steps once per eligible bit
    chk_count_step: assert property (@(posedge clk) disable iff (sys_rst)
        (armed && eligible && bit_cnt_q < limit) |=> (bit_cnt_q == $past(bit_cnt_q) + 1'b1))
        else $error("counter did not step");
    // counter restarts after the last bit
    chk_count_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        (armed && eligible && bit_cnt_q >= limit) |=> (bit_cnt_q == '0))
        else $error("counter did not restart");
    chk_idle_clear: assert property (@(posedge clk) disable iff (sys_rst)
        !armed |=> (bit_cnt_q == '0))
        else $error("counter not cleared when idle");
    // lowest code gives one in 16
    chk_rate_min: assert property (@(posedge clk) disable iff (sys_rst)
        (active_rate_q == 4'h1) |-> (limit == 18'h0000f))
        else $error("wrong period for lowest code");
    // highest code gives one in 262144
    chk_rate_max: assert property (@(posedge clk) disable iff (sys_rst)
        (active_rate_q == 4'hf) |-> (limit == 18'h3ffff))
        else $error("wrong period for highest code");
    // constant mode leaves remaining count alone
    chk_constant_keep: assert property (@(posedge clk) disable iff (sys_rst)
        (mode == MODE_CONSTANT && !load_pending_q) |=> (left_q == $past(left_q)))
        else $error("remaining changed in constant mode");
    // remaining changes only on error or load
    chk_left_stable: assert property (@(posedge clk) disable iff (sys_rst)
        (!hit && !load_pending_q) |=> $stable(left_q))
        else $error("remaining changed without cause");
    // rate taken from control at frame start
    chk_rate_latch: assert property (@(posedge clk) disable iff (sys_rst)
        (tx_in.valid && tx_in.frame_start) |=> (active_rate_q == $past(control_q[3:0])))
        else $error("rate not taken at frame start");
    // load only after a rising load bit
    chk_load_edge: assert property (@(posedge clk) disable iff (sys_rst)
        load_pending_q |-> ($past(control_q[LOAD_BIT]) && !$past(load_prev_q)))
        else $error("load without rising edge");
    chk_rdata_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !host_req.rd |=> $stable(host_rdata))
        else $error("read data changed without read");
    chk_left_read: assert property (@(posedge clk) disable iff (sys_rst)
        (host_req.rd && host_req.addr == ERRORS_LEFT_LOW_ADDR) |=> (host_rdata == $past(left_q[7:0])))
        else $error("wrong low remaining byte");
    chk_left_read_high: assert property (@(posedge clk) disable iff (sys_rst)
        (host_req.rd && host_req.addr == ERRORS_LEFT_HIGH_ADDR)
        |=> (host_rdata == {6'h00, $past(left_q[9:8])}))
        else $error("wrong high remaining bits");

    // main scenarios
    cov_chan_hit: cover property (@(posedge clk) disable iff (sys_rst) chan_only && hit);
    cov_rate_switch: cover property (@(posedge clk) disable iff (sys_rst)
        tx_in.valid && tx_in.frame_start && active_rate_q != control_q[3:0]);
    cov_constant_hit: cover property (@(posedge clk) disable iff (sys_rst)
        mode == MODE_CONSTANT && hit);
    cov_counted_done: cover property (@(posedge clk) disable iff (sys_rst)
        mode == MODE_COUNTED && hit && left_q == 10'h001);
    cov_load: cover property (@(posedge clk) disable iff (sys_rst) load_pending_q);

endmodule // t1_payload_error_inserter

// file: pkg/err_ins_pkg.sv
package err_ins_pkg;

    // register offsets on the byte-wide host port
    localparam logic [7:0] ERROR_RATE_CONTROL_ADDR = 8'he0;
    localparam logic [7:0] ERROR_COUNT_LOW_ADDR = 8'hec;
    localparam logic [7:0] ERROR_COUNT_HIGH_ADDR = 8'hed;
    localparam logic [7:0] ERRORS_LEFT_LOW_ADDR = 8'hee;
    localparam logic [7:0] ERRORS_LEFT_HIGH_ADDR = 8'hef;

    // control register field positions
    localparam int RATE_CODE_LSB = 0;
    localparam int CONSTANT_BIT = 4;
    localparam int LOAD_BIT = 7;

    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [9:0] COUNT_RESET = 10'h000;

    // rate code c gives 1 error in 2^(c+3) bits
    localparam int RATE_SHIFT = 3;
    localparam int BIT_COUNT_W = 18;

    // host register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    // one transmit bit with its framing marks
    typedef struct packed {
        logic valid;
        logic data;
        logic framing;
        logic frame_start;
        logic chan_sel;
    } tx_bit_t;

    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_CONSTANT = 2'b01,
        MODE_COUNTED = 2'b10
    } ins_mode_t;

endpackage

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import err_ins_pkg::*;
    logic clk = 0, sys_rst = 1, t1_mode = 1, chan_only = 0, run = 0;
    host_req_t host_req = '0;
    tx_bit_t tx_in;
    logic [7:0] host_rdata, ctrl_m, lo_m, hi_m;
    logic tx_out_valid, tx_out_data, tx_out_framing, tx_out_frame_start, error_inserted;
    logic [4:0] exp_q;
    int bad_count = 0, total_checks = 0, cycles = 0, cnt_m, left_m, rate_m;
    always #10 clk = ~clk;
    tx_stream_src src (.clk(clk), .run(run), .tx(tx_in));
    t1_payload_error_inserter uut (.clk(clk), .sys_rst(sys_rst), .host_req(host_req),
        .host_rdata(host_rdata), .t1_mode(t1_mode), .chan_only(chan_only), .tx_in(tx_in),
        .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data), .tx_out_framing(tx_out_framing),
        .tx_out_frame_start(tx_out_frame_start), .error_inserted(error_inserted));
    task automatic check(string what, logic [9:0] exp, logic [9:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic test_done;
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // host access, launched and released on falling edges
    task automatic reg_wr(logic [7:0] a, logic [7:0] d);
        host_req <= '{1'b1, 1'b0, a, d};
        @(negedge clk) host_req <= '0;
        @(negedge clk);
    endtask
    task automatic reg_rd(logic [7:0] a, logic [7:0] e);
        host_req <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk) host_req <= '0;
        check("read", e, host_rdata);
        @(negedge clk);
    endtask
    // reference model: payload count, inversion and remaining errors
    always @(posedge clk) begin
        logic flip;
        flip = 0;
        if (sys_rst) begin
            {ctrl_m, lo_m, hi_m, exp_q, cnt_m, left_m, rate_m} = '0;
        end else begin
            if (tx_in.valid && tx_in.frame_start) rate_m = ctrl_m[3:0];
            if (t1_mode && rate_m != 0 && (ctrl_m[4] || left_m != 0)) begin
                if (tx_in.valid && !tx_in.framing && (!chan_only || tx_in.chan_sel)) cnt_m++;
                if (cnt_m == (1 << (rate_m + 3))) begin
                    flip = 1;
                    cnt_m = 0;
                    if (!ctrl_m[4]) left_m--;
                end
            end else cnt_m = 0;
            exp_q = {tx_in.valid, tx_in.data ^ flip, tx_in.framing, tx_in.frame_start, flip};
            // load only on a rising load bit
            if (host_req.wr && host_req.addr == ERROR_RATE_CONTROL_ADDR) begin
                if (!ctrl_m[7] && host_req.wdata[7]) left_m = {hi_m[1:0], lo_m};
                ctrl_m = host_req.wdata;
            end
            if (host_req.wr && host_req.addr == ERROR_COUNT_LOW_ADDR) lo_m = host_req.wdata;
            if (host_req.wr && host_req.addr == ERROR_COUNT_HIGH_ADDR) hi_m = host_req.wdata;
        end
    end
    always @(negedge clk) check("stream", 10'(exp_q), {tx_out_valid, tx_out_data,
        tx_out_framing, tx_out_frame_start, error_inserted});
    // hang guard, well above the planned run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            test_done;
        end
    end
    task automatic read_left;
        reg_rd(ERRORS_LEFT_LOW_ADDR, 8'(left_m));
        reg_rd(ERRORS_LEFT_HIGH_ADDR, 8'(left_m >> 8));
    endtask
    initial begin
        void'($urandom(32'h0f91bf28));
        repeat (12) @(negedge clk);
        sys_rst <= 0;
        @(negedge clk);
        for (int a = 'hec; a <= 'hef; a++) reg_rd(8'(a), 8'h00);
        reg_rd(ERROR_RATE_CONTROL_ADDR, 8'h00);
        reg_rd(8'h55, 8'h00);
        run = 1;
        // every nonzero rate code, switched mid-frame, the odd codes channel-limited
        for (int c = 1; c < 16; c++) begin
            chan_only = c[0];
            reg_wr(ERROR_RATE_CONTROL_ADDR, 8'(8'h10 | c));
            repeat (300) @(negedge clk);
        end
        chan_only = 0;
        reg_wr(ERROR_RATE_CONTROL_ADDR, 8'h10);
        repeat (400) @(negedge clk);
        t1_mode = 0;
        reg_wr(ERROR_RATE_CONTROL_ADDR, 8'h11);
        repeat (400) @(negedge clk);
        t1_mode = 1;
        run = 0;
        reg_wr(ERROR_RATE_CONTROL_ADDR, 8'h01);
        reg_wr(ERROR_COUNT_LOW_ADDR, 8'($urandom));
        reg_wr(ERROR_COUNT_HIGH_ADDR, 8'h01);
        reg_wr(ERROR_RATE_CONTROL_ADDR, 8'h81);
        repeat (4) @(negedge clk);
        read_left;
        reg_wr(ERRORS_LEFT_LOW_ADDR, 8'h00);
        run = 1;
        repeat (500) @(negedge clk);
        run = 0;
        reg_wr(ERROR_COUNT_LOW_ADDR, 8'h07);
        reg_wr(ERROR_RATE_CONTROL_ADDR, 8'h81);
        repeat (3) @(negedge clk);
        read_left;
        run = 1;
        repeat (9000) @(negedge clk);
        run = 0;
        repeat (3) @(negedge clk);
        read_left;
        reg_wr(ERROR_RATE_CONTROL_ADDR, 8'h01);
        reg_wr(ERROR_RATE_CONTROL_ADDR, 8'h81);
        repeat (4) @(negedge clk);
        read_left;
        test_done;
    end
endmodule // tb_top

// file: test/tx_stream_src.sv
`timescale 1ns/1ps
module tx_stream_src (
    // clock and control
    input wire logic clk,
    input wire logic run,
    // stream towards the inserter
    output err_ins_pkg::tx_bit_t tx
);
    import err_ins_pkg::*;
    int pos = 0;
    initial tx = '0;
    // bits launched on the falling edge; a frame restarts with each run
    always @(negedge clk) begin
        if (!run) begin
            pos = 0;
            tx <= {1'b0, ~tx.data, 3'b000};
        end else begin
            tx <= {1'b1, 1'($urandom), pos == 0, pos == 0, 1'($urandom)};
            pos = (pos == 192) ? 0 : pos + 1;
        end
    end
endmodule // tx_stream_src
